// ---- spm_baud.sv ----
`timescale 1ns/1ps
// Half-period tick: divisor = (prescale+1) * 2^(rate+1) / 2 clocks
module spm_baud (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] prescale_sel,
  input  wire logic [2:0] rate_sel,
  // Tick
  output logic            tick
);
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic        next_tick;
  logic [11:0] limit;

  always_comb begin
    limit     = 12'(({9'h000, prescale_sel} + 12'h001) << rate_sel) - 12'h001;
    next_cnt  = 12'h000;
    next_tick = 1'b0;
    if (run) begin
      if (cnt >= limit) begin
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt  <= 12'h000;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ---- spm_pkg.sv ----
// Contract
// - While the port is enabled the four serial pins (select, clock, master-out, master-in) belong to the port.
// - As master a transfer starts when software reads status with the transmit-empty flag set and then writes the data buffer.
// - At the end of each transfer the received shift-register byte moves into the receive buffer.
// - The data registers return the receive buffer on reads and load the transmit buffer on writes.
// - Polarity and phase bits pick one of four clock formats; polarity just inverts the serial clock.
// - Phase clear samples on odd serial clock edges, phase set on even edges, and both ends must agree.
// - The port is master while the master-select bit is set and slave while it is clear.
// - Only the master starts a transmission; a slave waits for the external master to clock data.
// - A written byte goes straight into an empty shift register and shifts out on master-out; as slave the code shifts it out on master-in.
// - The master serial clock comes from a baud generator set by three rate and three prescale bits.
// - As master the port drives the serial clock pin and the slave shifts on that clock.
// - As master the roles of master-out and master-in follow the single-pin mode and bidirectional output bits.
// - With mode-fault and select-output enable both set, select is driven low during each transfer and high when idle.
// - With mode-fault enable set and select-output enable clear, select is an input and a low level in master role is a mode fault.
package spm_pkg;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_BAUD   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_DATA   = 4'hC;
  localparam logic [3:0] ADDR_IMASK  = 4'h0; // Unused; the interrupt mask is bits 5:3 of the status register
  localparam int         CTL_EN     = 6;
  localparam int         CTL_MASTER  = 4;
  localparam int         CTL_POL     = 3;
  localparam int         CTL_PHA     = 2;
  localparam int         CTL_SELOUT  = 1;
  localparam int         CTL_FAULTEN = 0;
  localparam int         CTL_ONEPIN  = 7;
  localparam int         CTL_BIDIR  = 8;
  localparam int         ST_RXF     = 0;
  localparam int         ST_TXE     = 1;
  localparam int         ST_MODF    = 2;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [3:0] BIT_LAST   = 4'hF;

  typedef struct packed {
    logic       bidir_output_enable;
    logic       single_pin_mode;
    logic       port_enable;
    logic       master_select;
    logic       clock_polarity_sel;
    logic       clock_phase_sel;
    logic       select_output_enable;
    logic       mode_fault_enable;
  } spm_ctrl_type;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_o;
    logic ss_oe;
  } spm_pins_type;
endpackage

// ---- spm_port.sv ----
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module spm_port (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq,
  // Serial pins
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  input  wire logic        miso_i,
  input  wire logic        ss_i,
  output spm_pkg::spm_pins_type pins
);
  typedef enum logic [1:0] {
    SPM_IDLE = 2'b00,
    SPM_LEAD = 2'b01,
    SPM_SHIFT = 2'b10
  } spm_state_type;

  spm_pkg::spm_ctrl_type ctrl, next_ctrl;
  logic [5:0]  baud, next_baud;
  logic [2:0]  stat, next_stat;
  logic [2:0]  imask, next_imask;
  logic [7:0]  txbuf, next_txbuf;
  logic [7:0]  rxbuf, next_rxbuf;
  logic [7:0]  shreg, next_shreg;
  logic        txpend, next_txpend;
  logic        armed, next_armed;
  logic [3:0]  edges, next_edges;
  logic        sck_int, next_sck_int;
  logic        sample, next_sample;
  spm_state_type state, next_state;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        next_irq;
  spm_pkg::spm_pins_type next_pins;
  logic        tick;
  logic        sck_prev;
  logic        bus_req, wr, rd;
  logic        s_edge, s_active, in_bit, sample_edge;

  spm_baud u_baud (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .run          (state != SPM_IDLE),
    .prescale_sel (baud[5:3]),
    .rate_sel     (baud[2:0]),
    .tick         (tick)
  );

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = bus_req & wb_we_i & wb_sel_i[0];
  assign rd      = bus_req & ~wb_we_i;
  // Slave edges: select low and serial clock changed
  assign s_active = ctrl.port_enable & ~ctrl.master_select & ~ss_i;
  assign s_edge   = s_active & (sck_i ^ sck_prev);
  // Data in: in master role single-pin mode shares master-out as the bidirectional line; a slave always takes master-out
  assign in_bit = ctrl.master_select ?
                  (ctrl.single_pin_mode ? mosi_i : miso_i) : mosi_i;

  always_comb begin
    next_ctrl  = ctrl;
    next_baud  = baud;
    next_imask = imask;
    next_txbuf = txbuf;
    next_rxbuf = rxbuf;
    next_shreg = shreg;
    next_txpend = txpend;
    next_armed = armed;
    next_edges = edges;
    next_sck_int = sck_int;
    next_sample = sample;
    next_state = state;
    next_stat  = stat;
    next_dat   = 32'h0000_0000;
    next_ack   = bus_req;
    sample_edge = 1'b0;
    // Status read arms the write that follows
    if (rd && wb_adr_i == spm_pkg::ADDR_STATUS && !txpend) begin
      next_armed = 1'b1;
    end
    if (rd) begin
      case (wb_adr_i)
        spm_pkg::ADDR_CTRL:   next_dat = {23'h0, ctrl.bidir_output_enable, ctrl.single_pin_mode,
                                          ctrl.port_enable, 1'b0, ctrl.master_select,
                                          ctrl.clock_polarity_sel, ctrl.clock_phase_sel,
                                          ctrl.select_output_enable, ctrl.mode_fault_enable};
        spm_pkg::ADDR_BAUD:   next_dat = {26'h0, baud};
        spm_pkg::ADDR_STATUS: next_dat = {26'h0, imask, stat[2], ~txpend, stat[0]};
        spm_pkg::ADDR_DATA:   next_dat = {24'h0, rxbuf};
        default:              next_dat = 32'h0000_0000;
      endcase
      if (wb_adr_i == spm_pkg::ADDR_DATA) begin
        next_stat[spm_pkg::ST_RXF] = 1'b0;
      end
    end
    if (wr) begin
      case (wb_adr_i)
        spm_pkg::ADDR_CTRL: begin
          next_ctrl.mode_fault_enable    = wb_dat_i[spm_pkg::CTL_FAULTEN];
          next_ctrl.select_output_enable = wb_dat_i[spm_pkg::CTL_SELOUT];
          next_ctrl.clock_phase_sel      = wb_dat_i[spm_pkg::CTL_PHA];
          next_ctrl.clock_polarity_sel   = wb_dat_i[spm_pkg::CTL_POL];
          next_ctrl.master_select        = wb_dat_i[spm_pkg::CTL_MASTER];
          next_ctrl.port_enable          = wb_dat_i[spm_pkg::CTL_EN];
          next_ctrl.single_pin_mode      = wb_dat_i[spm_pkg::CTL_ONEPIN];
          next_ctrl.bidir_output_enable  = wb_dat_i[spm_pkg::CTL_BIDIR];
        end
        spm_pkg::ADDR_BAUD:   next_baud = wb_dat_i[5:0];
        spm_pkg::ADDR_STATUS: begin
          next_stat[spm_pkg::ST_MODF] = stat[spm_pkg::ST_MODF] & ~wb_dat_i[spm_pkg::ST_MODF];
          next_imask = wb_dat_i[5:3];
        end
        spm_pkg::ADDR_DATA: begin
          if (armed || !ctrl.master_select) begin
            next_txbuf  = wb_dat_i[7:0];
            next_txpend = 1'b1;
          end
          next_armed = 1'b0;
        end
        default: ;
      endcase
    end
    case (state)
      SPM_IDLE: begin
        next_sck_int = 1'b0;
        next_edges   = 4'h0;
        if (txpend && ctrl.port_enable) begin
          next_shreg  = txbuf;
          next_txpend = 1'b0;
          if (ctrl.master_select) begin
            next_state = SPM_LEAD;
          end else begin
            next_state = SPM_SHIFT;
          end
        end else if (s_active) begin
          next_state = SPM_SHIFT;
        end
      end
      SPM_LEAD: begin
        if (tick) begin
          next_state = SPM_SHIFT;
        end
      end
      SPM_SHIFT: begin
        if (ctrl.master_select ? tick : s_edge) begin
          next_sck_int = ~sck_int;
          next_edges   = edges + 4'h1;
          // Odd edges sample when phase clear, even edges when set
          sample_edge  = edges[0] == ctrl.clock_phase_sel;
          if (sample_edge) begin
            next_sample = in_bit;
          // Phase set: the first edge only launches the bit already on the line
          end else if (edges != 4'h0) begin
            next_shreg = {shreg[6:0], sample};
          end
          if (edges == spm_pkg::BIT_LAST) begin
            next_rxbuf = {shreg[6:0], ctrl.clock_phase_sel ? in_bit : sample};
            next_stat[spm_pkg::ST_RXF] = 1'b1;
            next_state = SPM_IDLE;
          end
        end
        if (!ctrl.port_enable || (!ctrl.master_select && ss_i)) begin
          next_state = SPM_IDLE;
        end
      end
      default: next_state = SPM_IDLE;
    endcase
    // Fault detection wins over a clear in the same cycle
    if (ctrl.port_enable && ctrl.master_select && ctrl.mode_fault_enable &&
        !ctrl.select_output_enable && !ss_i) begin
      next_stat[spm_pkg::ST_MODF] = 1'b1;
      next_ctrl.master_select     = 1'b0;
      next_state                  = SPM_IDLE;
    end
    next_irq = |(next_stat & imask);
    // Pin drive
    next_pins = '0;
    next_pins.ss_o = 1'b1;
    if (ctrl.port_enable) begin
      if (ctrl.master_select) begin
        next_pins.sck_o  = next_sck_int ^ ctrl.clock_polarity_sel;
        next_pins.sck_oe = 1'b1;
        next_pins.mosi_o = next_shreg[7];
        next_pins.mosi_oe = ~ctrl.single_pin_mode | ctrl.bidir_output_enable;
        next_pins.ss_oe  = ctrl.mode_fault_enable & ctrl.select_output_enable;
        // One clock late on purpose: select never moves with a clock edge
        next_pins.ss_o   = state == SPM_IDLE;
      end else begin
        next_pins.miso_o  = next_shreg[7];
        next_pins.miso_oe = ~ss_i;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl     <= spm_pkg::spm_ctrl_type'(spm_pkg::RST_CTRL);
      baud     <= 6'h00;
      stat     <= 3'h0;
      imask    <= 3'h0;
      txbuf    <= 8'h00;
      rxbuf    <= 8'h00;
      shreg    <= 8'h00;
      txpend   <= 1'b0;
      armed    <= 1'b0;
      edges    <= 4'h0;
      sck_int  <= 1'b0;
      sample   <= 1'b0;
      state    <= SPM_IDLE;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      irq      <= 1'b0;
      pins     <= '{ss_o: 1'b1, default: 1'b0};
      sck_prev <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      baud     <= next_baud;
      stat     <= next_stat;
      imask    <= next_imask;
      txbuf    <= next_txbuf;
      rxbuf    <= next_rxbuf;
      shreg    <= next_shreg;
      txpend   <= next_txpend;
      armed    <= next_armed;
      edges    <= next_edges;
      sck_int  <= next_sck_int;
      sample   <= next_sample;
      state    <= next_state;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      irq      <= next_irq;
      pins     <= next_pins;
      sck_prev <= sck_i;
    end
  end

  property p_fault_flag;
    @(posedge clk) disable iff (sys_rst)
    (ctrl.port_enable && ctrl.master_select && ctrl.mode_fault_enable &&
     !ctrl.select_output_enable && !ss_i) |=> stat[spm_pkg::ST_MODF];
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("mode fault not flagged");

  property p_ss_idle;
    @(posedge clk) disable iff (sys_rst)
    (state == SPM_IDLE && ctrl.master_select && ctrl.port_enable) |=> pins.ss_o;
  endproperty
  a_ss_idle: assert property (p_ss_idle) else $error("select low while idle");

  property p_rx_done;
    @(posedge clk) disable iff (sys_rst)
    (state == SPM_SHIFT && next_state == SPM_IDLE && edges == spm_pkg::BIT_LAST)
      |=> stat[spm_pkg::ST_RXF];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive flag not set");

  property p_slave_no_clk;
    @(posedge clk) disable iff (sys_rst) !ctrl.master_select |=> !pins.sck_oe;
  endproperty
  a_slave_no_clk: assert property (p_slave_no_clk) else $error("slave drove clock");

  property p_master_clk;
    @(posedge clk) disable iff (sys_rst)
    (ctrl.master_select && ctrl.port_enable) |=> pins.sck_oe;
  endproperty
  a_master_clk: assert property (p_master_clk) else $error("master clock not driven");

  property p_idle_pol;
    @(posedge clk) disable iff (sys_rst)
    (state == SPM_IDLE && ctrl.master_select && ctrl.port_enable && $stable(ctrl))
      |=> pins.sck_o == $past(ctrl.clock_polarity_sel);
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("idle clock level wrong");

  property p_disabled;
    @(posedge clk) disable iff (sys_rst)
    !ctrl.port_enable |=> !pins.sck_oe && !pins.mosi_oe && !pins.miso_oe;
  endproperty
  a_disabled: assert property (p_disabled) else $error("pins driven while off");

  property p_start;
    @(posedge clk) disable iff (sys_rst)
    (state == SPM_IDLE && txpend && ctrl.port_enable && ctrl.master_select && ss_i)
      |=> state == SPM_LEAD;
  endproperty
  a_start: assert property (p_start) else $error("master did not start");

  c_master: cover property (@(posedge clk) state == SPM_SHIFT && ctrl.master_select);
  c_slave: cover property (@(posedge clk) state == SPM_SHIFT && !ctrl.master_select);
  c_fault: cover property (@(posedge clk) stat[spm_pkg::ST_MODF]);
  c_phase: cover property (@(posedge clk) state == SPM_SHIFT && ctrl.clock_phase_sel);
endmodule

// ---- spm_port_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module spm_port_tb_top;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  wb_cyc, wb_stb, wb_we, ss_i, clk_pol, clk_pha;
  logic [3:0]            wb_adr;
  logic [31:0]           wb_dat, q, seed;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o, irq, miso_m, sck_w, mosi_w, miso_w, ss_w;
  logic [7:0]            s_tx, s_rx, s_edges;
  logic [1:0]            md;
  spm_pkg::spm_pins_type pins;
  int                    err_total, tests_run;

  always #2.5 clk = ~clk;

  // Each shared line but master-out resolves from whoever drives it; undriven master-out shows the inverse of mosi_o
  assign sck_w  = pins.sck_oe ? pins.sck_o : clk_pol;
  assign mosi_w = pins.mosi_oe ? pins.mosi_o : ~pins.mosi_o;
  assign miso_w = pins.miso_oe ? pins.miso_o : miso_m;
  assign ss_w   = pins.ss_oe ? pins.ss_o : ss_i;

  spm_port u_spm_port (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
    .ss_i(ss_w), .pins(pins));

  spm_slave_model u_spm_slave_model (
    .sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .phase(clk_pha), .tx_byte(s_tx),
    .miso(miso_m), .rx_byte(s_rx), .edge_cnt(s_edges));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] exp_st(input logic [2:0] mask, input logic modf,
                                         input logic rxf);
    return {26'h0, mask, modf, 1'b1, rxf};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Called just after a rising edge; ack and read data are taken at the same edge
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      end_sim();
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_ss(input logic lvl);
    int n;
    n = 0;
    while (pins.ss_o !== lvl && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) begin
      err_total++;
      end_sim();
    end
  endtask

  initial begin
    {wb_cyc, wb_stb, wb_we, ss_i, clk_pol, clk_pha} = 6'h04;
    wb_adr = 4'h0;
    wb_dat = 32'h0;
    s_tx = 8'h00;
    seed = 32'h7A9624E9;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, spm_pkg::ADDR_CTRL, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
    `CHK(q, exp_st(3'b000, 1'b0, 1'b0))
    bus(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    `CHK(irq, 1'b0)
    for (int m = 0; m < 6; m++) begin
      seed = lfsr(seed);
      md = (m < 4) ? m[1:0] : seed[9:8];
      clk_pol <= md[1];
      clk_pha <= md[0];
      s_tx <= seed[7:0];
      bus(1'b1, spm_pkg::ADDR_CTRL, 32'h53 | {28'h0, md, 2'b00});
      bus(1'b1, spm_pkg::ADDR_BAUD, {26'h0, seed[13:11], 1'b0, seed[10:9]});
      bus(1'b1, spm_pkg::ADDR_STATUS, 32'h08);
      bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
      `CHK(q[1], 1'b1)
      bus(1'b1, spm_pkg::ADDR_DATA, {24'h0, seed[23:16]});
      wait_ss(1'b0);
      `CHK(pins.sck_oe, 1'b1)
      `CHK({pins.mosi_oe, pins.miso_oe, pins.ss_oe}, 3'b101)
      wait_ss(1'b1);
      `CHK(pins.sck_o, md[1])
      `CHK(s_edges, 8'h10)
      `CHK(s_rx, seed[23:16])
      bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
      `CHK(q, exp_st(3'b001, 1'b0, 1'b1))
      `CHK(irq, 1'b1)
      bus(1'b0, spm_pkg::ADDR_DATA, 32'h0);
      `CHK(q, {24'h0, seed[7:0]})
      `CHK(irq, 1'b0)
    end
    // Single-pin master: the shared data line drives only with the bidir enable
    bus(1'b1, spm_pkg::ADDR_CTRL, 32'hD0);
    `CHK(pins.mosi_oe, 1'b0)
    bus(1'b1, spm_pkg::ADDR_CTRL, 32'h1D0);
    `CHK(pins.mosi_oe, 1'b1)
    bus(1'b1, spm_pkg::ADDR_CTRL, 32'h51);
    bus(1'b1, spm_pkg::ADDR_STATUS, 32'h20);
    ss_i <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
    `CHK(q, exp_st(3'b100, 1'b1, 1'b0))
    `CHK(irq, 1'b1)
    bus(1'b0, spm_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[spm_pkg::CTL_MASTER], 1'b0)
    ss_i <= 1'b1;
    bus(1'b1, spm_pkg::ADDR_STATUS, 32'h24);
    bus(1'b0, spm_pkg::ADDR_STATUS, 32'h0);
    `CHK(q, exp_st(3'b100, 1'b0, 1'b0))
    // Slave role: a written byte must wait for an outside clock
    bus(1'b1, spm_pkg::ADDR_CTRL, 32'h40);
    bus(1'b1, spm_pkg::ADDR_DATA, 32'hA5);
    repeat (20) @(posedge clk);
    `CHK(pins.sck_oe, 1'b0)
    bus(1'b1, spm_pkg::ADDR_CTRL, 32'h0);
    `CHK({pins.sck_oe, pins.mosi_oe, pins.ss_oe}, 3'b000)
    end_sim();
  end
endmodule

// ---- spm_slave_model.sv ----
`timescale 1ns/1ps
module spm_slave_model (
  // Serial lines
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       phase,
  input  wire logic [7:0] tx_byte,
  // Observed results
  output logic            miso,
  output logic      [7:0] rx_byte,
  output logic      [7:0] edge_cnt
);
  logic [7:0] sh;

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    edge_cnt = 8'h00;
    sh = 8'h00;
  end

  always @(negedge ss_n) begin
    sh = tx_byte;
    edge_cnt = 8'h00;
    // Phase clear: first bit must be on the line before the first edge
    if (!phase) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end

  // Released line shows the inverse of the last bit so a stale value cannot pass
  always @(posedge ss_n) miso = ~miso;

  always @(sck) begin
    if (ss_n === 1'b0) begin
      edge_cnt = edge_cnt + 8'h01;
      if (edge_cnt[0] ^ phase) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else begin
        miso = sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule
